// ---- core/ucc_regs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef UCC_REGS_SVH
`define UCC_REGS_SVH

// Serial port addresses
`define UCC_ADDR_CFG1 5'h00
`define UCC_ADDR_CFG2 5'h01

// Instruction byte fields and frame length
`define UCC_INSTR_RD_BIT 7
`define UCC_INSTR_BITS 6'h08
`define UCC_FRAME_BITS 6'h28

// First control register fields
`define UCC_C1_MODE_HI 25
`define UCC_C1_MODE_LO 24
`define UCC_C1_AK_EN 9
`define UCC_C1_AK_AUTO 8
`define UCC_C1_DIG_PD 7
`define UCC_C1_DAC_PD 6
`define UCC_C1_REF_PD 5
`define UCC_C1_AUX_PD 4
`define UCC_C1_EXT_FAST 3
`define UCC_C1_AUTO_PD 2
`define UCC_C1_THREE_WIRE 1
`define UCC_C1_LSB_FIRST 0
`define UCC_C1_MASK 32'h030003ff
`define UCC_C1_RESET 32'h00000000

// Second control register fields
`define UCC_C2_DUAL_EN 31
`define UCC_C2_DUAL_LSB 30
`define UCC_C2_EARLY_FS 29
`define UCC_C2_ASF_PROF 24
`define UCC_C2_INT_UPD 23
`define UCC_C2_MASK 32'he1800000
`define UCC_C2_RESET 32'h00000000

// Operating modes
`define UCC_MODE_QUAD 2'h0
`define UCC_MODE_TONE 2'h1

// Baseband flush length in clock cycles
`define UCC_FLUSH_CYC 16

`endif

// ---- core/ucc_pkg.sv ----
// Types shared by the upconverter control register block
package ucc_pkg;

	typedef enum logic [2:0] {
		UCC_APD_RUN = 3'b001,
		UCC_APD_FLUSH = 3'b010,
		UCC_APD_STOP = 3'b100
	} ucc_apd_t;

	typedef struct packed {
		logic [31:0] cfg1_sh;
		logic [31:0] cfg2_sh;
		logic [31:0] cfg1_act;
		logic [31:0] cfg2_act;
		logic [2:0] upd_sync;
		logic [1:0] txen_sync;
		logic [1:0] pwdn_sync;
		ucc_apd_t apd;
		logic [7:0] flush_cnt;
		logic upd_out;
	} ucc_ctl_t;

	typedef struct packed {
		logic [2:0] sclk_s;
		logic [1:0] csn_s;
		logic [1:0] sdi_s;
		logic [5:0] cnt;
		logic [7:0] instr;
		logic [31:0] sh;
		logic [31:0] rd_word;
		logic sdo;
		logic wr;
	} ucc_sio_st_t;

endpackage

// ---- core/ucc_sio_if.sv ----
// Link between the serial port shifter and the register bank
`timescale 1ns/10ps
interface ucc_sio_if;
	logic wr_valid;
	logic [4:0] addr;
	logic [31:0] wr_data;
	logic [31:0] rd_data;
	logic lsb_first;
	logic three_wire;

	modport port (output wr_valid, output addr, output wr_data,
		input rd_data, input lsb_first, input three_wire);
	modport regs (input wr_valid, input addr, input wr_data,
		output rd_data, output lsb_first, output three_wire);
endinterface

// ---- core/ucc_sio.sv ----
// Serial programming port shifter
`timescale 1ns/10ps
`include "ucc_regs.svh"
module ucc_sio
	import ucc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdio_i,
	output logic sdo_bit_o,
	output logic sdio_oe_o,
	output logic sdo_oe_o,
	ucc_sio_if.port sio
);
	ucc_sio_st_t q;
	ucc_sio_st_t d;
	logic rise;
	logic fall;
	logic bit_in;
	logic rd_phase;
	logic [31:0] word;

	assign rise = q.sclk_s[1] & ~q.sclk_s[2];
	assign fall = ~q.sclk_s[1] & q.sclk_s[2];
	assign bit_in = q.sdi_s[1];
	assign rd_phase = ~q.csn_s[1] & q.instr[`UCC_INSTR_RD_BIT] & (q.cnt >= `UCC_INSTR_BITS);

	always_comb begin
		d = q;
		word = q.rd_word;
		d.sclk_s = {q.sclk_s[1:0], sclk_i};
		d.csn_s = {q.csn_s[0], cs_n_i};
		d.sdi_s = {q.sdi_s[0], sdio_i};
		d.wr = 1'b0;
		if (q.csn_s[1]) begin
			d.cnt = 6'h00;
			d.instr = 8'h00;
		end else if (rise && q.cnt < `UCC_FRAME_BITS) begin
			// Shift order follows the active bit-order setting
			if (q.cnt < `UCC_INSTR_BITS) begin
				d.instr = sio.lsb_first ? {bit_in, q.instr[7:1]} : {q.instr[6:0], bit_in};
			end else begin
				d.sh = sio.lsb_first ? {bit_in, q.sh[31:1]} : {q.sh[30:0], bit_in};
			end
			d.cnt = q.cnt + 6'h01;
			if (q.cnt == `UCC_FRAME_BITS - 6'h01 && !q.instr[`UCC_INSTR_RD_BIT]) begin
				d.wr = 1'b1;
			end
		end else if (fall && rd_phase) begin
			// Word is captured at the first data fall so late writes are seen
			word = (q.cnt == `UCC_INSTR_BITS) ? sio.rd_data : q.rd_word;
			d.sdo = sio.lsb_first ? word[0] : word[31];
			d.rd_word = sio.lsb_first ? {1'b0, word[31:1]} : {word[30:0], 1'b0};
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			q <= '{sclk_s: 3'h0, csn_s: 2'h3, sdi_s: 2'h0, cnt: 6'h00, instr: 8'h00,
				sh: 32'h0, rd_word: 32'h0, sdo: 1'b0, wr: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign sio.wr_valid = q.wr;
	assign sio.addr = q.instr[4:0];
	assign sio.wr_data = q.sh;
	assign sdo_bit_o = q.sdo;
	// Two-wire mode turns the data pin round; three-wire uses the output pin
	assign sdio_oe_o = rd_phase & ~sio.three_wire;
	assign sdo_oe_o = rd_phase & sio.three_wire;
endmodule

// ---- core/ucc_ctl.sv ----
// Upconverter control and configuration register bank
`timescale 1ns/10ps
`include "ucc_regs.svh"

// Behaviour
// - Bit 9 enables amplitude keying
// - Bit 8 picks automatic keying, needs bit 9
// - Bit 7 stops core clocks immediately
// - Bit 6 powers down main converter
// - Bit 5 powers down reference input immediately
// - Bit 4 powers down auxiliary converter
// - Bit 3 picks fast or full pin power-down
// - Bit 2 flushes, stops clocks while transmit low
// - Auto power-down ignored in single tone
// - Bit 1 selects three-wire, input-only data pin
// - Bit 0 sets serial port bit order
// - Second register sits at address 0x01
// - Bit 31 selects dual serial data port
// - Dual serial honoured only in quadrature mode
// - Bit 30 sets dual serial bit order
// - Bit 29 sets early frame sync
// - Bit 24 picks profile amplitude in tone with keying off
// - Bit 23 immediate, internal update drives pin
module ucc_ctl
	import ucc_pkg::*;
#(
	parameter int FLUSH_CYCLES = `UCC_FLUSH_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe_o,
	output logic sdo_o,
	output logic sdo_oe_o,
	input wire logic io_update_i,
	output logic io_update_o,
	output logic io_update_oe_o,
	input wire logic transmit_enable_pin_i,
	input wire logic external_powerdown_pin_i,
	output logic [1:0] opmode_o,
	output logic amplitude_keying_en_o,
	output logic amplitude_keying_auto_o,
	output logic core_clk_en_o,
	output logic bb_flush_o,
	output logic dac_pd_o,
	output logic reference_clock_input_pd_o,
	output logic aux_dac_pd_o,
	output logic full_pd_o,
	output logic fast_pd_o,
	output logic three_wire_o,
	output logic lsb_first_o,
	output logic dual_serial_host_port_en_o,
	output logic dual_serial_lsb_first_o,
	output logic dual_serial_early_fsync_o,
	output logic amplitude_scale_factor_profile_o,
	output logic amplitude_scale_factor_bypass_o
);

	generate
		if (FLUSH_CYCLES < 1 || FLUSH_CYCLES > 255) begin : g_bad_flush
			$error("FLUSH_CYCLES must lie in 1..255");
		end
	endgenerate

	localparam logic [7:0] FLUSH_LAST = 8'(FLUSH_CYCLES - 1);

	function automatic logic is_tone(input logic [1:0] mode);
		return mode == `UCC_MODE_TONE;
	endfunction

	function automatic logic is_quad(input logic [1:0] mode);
		return mode == `UCC_MODE_QUAD;
	endfunction

	ucc_sio_if sio ();

	ucc_sio u_sio (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.sclk_i(sclk_i),
		.cs_n_i(cs_n_i),
		.sdio_i(sdio_i),
		.sdo_bit_o(sdo_o),
		.sdio_oe_o(sdio_oe_o),
		.sdo_oe_o(sdo_oe_o),
		.sio(sio.port)
	);

	// Same bit on both pins; only the enable differs between wire modes
	assign sdio_o = sdo_o;

	ucc_ctl_t q;
	ucc_ctl_t d;
	logic upd_ext;
	logic upd_now;
	logic txen;
	logic [1:0] mode;
	logic apd_en;

	assign mode = q.cfg1_act[`UCC_C1_MODE_HI:`UCC_C1_MODE_LO];
	assign txen = q.txen_sync[1];
	assign upd_ext = q.upd_sync[1] & ~q.upd_sync[2];
	// Pin is only trusted as a strobe while it is an input
	assign upd_now = q.cfg2_act[`UCC_C2_INT_UPD] ? q.upd_out : upd_ext;
	assign apd_en = q.cfg1_act[`UCC_C1_AUTO_PD] & ~is_tone(mode);

	// Reads return written values so software sees what it wrote
	always_comb begin
		unique case (sio.addr)
			`UCC_ADDR_CFG1: sio.rd_data = q.cfg1_sh;
			`UCC_ADDR_CFG2: sio.rd_data = q.cfg2_sh;
			default: sio.rd_data = 32'h0;
		endcase
	end

	// Port format follows the active copy, so a change waits for an update
	assign sio.lsb_first = q.cfg1_act[`UCC_C1_LSB_FIRST];
	assign sio.three_wire = q.cfg1_act[`UCC_C1_THREE_WIRE];

	always_comb begin
		d = q;
		d.upd_sync = {q.upd_sync[1:0], io_update_i};
		d.txen_sync = {q.txen_sync[0], transmit_enable_pin_i};
		d.pwdn_sync = {q.pwdn_sync[0], external_powerdown_pin_i};
		d.upd_out = 1'b0;

		// Shadow to active transfer
		if (upd_now) begin
			d.cfg1_act = q.cfg1_sh;
			d.cfg2_act = q.cfg2_sh;
		end

		// A write in the update cycle lands after the transfer and waits
		if (sio.wr_valid) begin
			unique case (sio.addr)
				`UCC_ADDR_CFG1: begin
					d.cfg1_sh = sio.wr_data & `UCC_C1_MASK;
					d.cfg1_act[`UCC_C1_DIG_PD] = sio.wr_data[`UCC_C1_DIG_PD];
					d.cfg1_act[`UCC_C1_REF_PD] = sio.wr_data[`UCC_C1_REF_PD];
				end
				`UCC_ADDR_CFG2: begin
					d.cfg2_sh = sio.wr_data & `UCC_C2_MASK;
					d.cfg2_act[`UCC_C2_INT_UPD] = sio.wr_data[`UCC_C2_INT_UPD];
				end
				default: begin
					d.cfg1_sh = q.cfg1_sh;
				end
			endcase
			// Internal mode issues its own strobe after each write
			if (d.cfg2_act[`UCC_C2_INT_UPD]) begin
				d.upd_out = 1'b1;
			end
		end

		// Automatic power-down sequencer
		unique case (q.apd)
			UCC_APD_RUN: begin
				if (apd_en && !txen) begin
					d.apd = UCC_APD_FLUSH;
					d.flush_cnt = 8'h00;
				end
			end
			UCC_APD_FLUSH: begin
				// Transmit back high before the flush ends: resume without stopping
				if (txen || !apd_en) begin
					d.apd = UCC_APD_RUN;
				end else if (q.flush_cnt == FLUSH_LAST) begin
					d.apd = UCC_APD_STOP;
				end else begin
					d.flush_cnt = q.flush_cnt + 8'h01;
				end
			end
			UCC_APD_STOP: begin
				if (txen || !apd_en) begin
					d.apd = UCC_APD_RUN;
				end
			end
			default: begin
				d.apd = UCC_APD_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			q <= '{cfg1_sh: `UCC_C1_RESET, cfg2_sh: `UCC_C2_RESET,
				cfg1_act: `UCC_C1_RESET, cfg2_act: `UCC_C2_RESET,
				upd_sync: 3'h0, txen_sync: 2'h0, pwdn_sync: 2'h0,
				apd: UCC_APD_RUN, flush_cnt: 8'h00, upd_out: 1'b0};
		end else begin
			q <= d;
		end
	end

	// Update pin turns round as soon as the mode bit is written
	assign io_update_o = q.upd_out;
	assign io_update_oe_o = q.cfg2_act[`UCC_C2_INT_UPD];

	assign opmode_o = mode;

	// Amplitude keying
	assign amplitude_keying_en_o = q.cfg1_act[`UCC_C1_AK_EN];
	assign amplitude_keying_auto_o = q.cfg1_act[`UCC_C1_AK_EN]
		& q.cfg1_act[`UCC_C1_AK_AUTO];

	// Power control
	assign core_clk_en_o = ~q.cfg1_act[`UCC_C1_DIG_PD]
		& (q.apd != UCC_APD_STOP);
	assign bb_flush_o = (q.apd == UCC_APD_FLUSH);
	assign dac_pd_o = q.cfg1_act[`UCC_C1_DAC_PD];
	assign reference_clock_input_pd_o = q.cfg1_act[`UCC_C1_REF_PD];
	assign aux_dac_pd_o = q.cfg1_act[`UCC_C1_AUX_PD];
	assign full_pd_o = q.pwdn_sync[1] & ~q.cfg1_act[`UCC_C1_EXT_FAST];
	assign fast_pd_o = q.pwdn_sync[1] & q.cfg1_act[`UCC_C1_EXT_FAST];

	// Serial programming port format
	assign three_wire_o = q.cfg1_act[`UCC_C1_THREE_WIRE];
	assign lsb_first_o = q.cfg1_act[`UCC_C1_LSB_FIRST];

	// Data port; sub-settings mean nothing unless the dual port is live
	assign dual_serial_host_port_en_o = q.cfg2_act[`UCC_C2_DUAL_EN]
		& is_quad(mode);
	assign dual_serial_lsb_first_o = dual_serial_host_port_en_o
		& q.cfg2_act[`UCC_C2_DUAL_LSB];
	assign dual_serial_early_fsync_o = dual_serial_host_port_en_o
		& q.cfg2_act[`UCC_C2_EARLY_FS];

	// Amplitude source in single tone with keying off
	assign amplitude_scale_factor_profile_o = is_tone(mode)
		& ~q.cfg1_act[`UCC_C1_AK_EN] & q.cfg2_act[`UCC_C2_ASF_PROF];
	assign amplitude_scale_factor_bypass_o = is_tone(mode)
		& ~q.cfg1_act[`UCC_C1_AK_EN] & ~q.cfg2_act[`UCC_C2_ASF_PROF];

endmodule

// ---- dv/ucc_ctl_chk.sv ----
// Assertion checker bound to the control register block
`timescale 1ns/10ps
module ucc_ctl_chk #(
	parameter int FLUSH_CYCLES = 16
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic io_update_i,
	input wire logic io_update_o,
	input wire logic [1:0] opmode_o,
	input wire logic amplitude_keying_en_o,
	input wire logic amplitude_keying_auto_o,
	input wire logic core_clk_en_o,
	input wire logic bb_flush_o,
	input wire logic full_pd_o,
	input wire logic fast_pd_o,
	input wire logic three_wire_o,
	input wire logic lsb_first_o,
	input wire logic sdio_oe_o,
	input wire logic sdo_oe_o,
	input wire logic dual_serial_host_port_en_o,
	input wire logic dual_serial_lsb_first_o,
	input wire logic dual_serial_early_fsync_o,
	input wire logic amplitude_scale_factor_profile_o,
	input wire logic amplitude_scale_factor_bypass_o
);
	logic [7:0] fl_q;
	// Length of the current flush run
	always_ff @(posedge ref_clk_i) begin
		fl_q <= (!rstn_i || !bb_flush_o) ? 8'h00 : fl_q + 8'h01;
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	a_auto_needs_en: assert property (amplitude_keying_auto_o |-> amplitude_keying_en_o)
		else $error("automatic keying without keying enable");
	a_pd_pin_excl: assert property (!(full_pd_o && fast_pd_o))
		else $error("both pin power-down kinds active");
	a_flush_len: assert property ($fell(bb_flush_o) && !core_clk_en_o |->
		fl_q == 8'(FLUSH_CYCLES)) else $error("flush length wrong before clock stop");
	a_flush_not_tone: assert property (bb_flush_o |-> opmode_o != 2'h1)
		else $error("flush in single tone mode");
	a_sdio_two_wire: assert property (sdio_oe_o |-> !three_wire_o && !sdo_oe_o)
		else $error("data pin driven in three-wire mode");
	a_dual_quad: assert property (dual_serial_host_port_en_o |-> opmode_o == 2'h0)
		else $error("dual serial port outside quadrature mode");
	a_dual_subs: assert property (dual_serial_lsb_first_o || dual_serial_early_fsync_o
		|-> dual_serial_host_port_en_o) else $error("dual serial setting without port");
	a_asf_tone: assert property (amplitude_scale_factor_profile_o ||
		amplitude_scale_factor_bypass_o |-> opmode_o == 2'h1 && !amplitude_keying_en_o &&
		!(amplitude_scale_factor_profile_o && amplitude_scale_factor_bypass_o))
		else $error("amplitude source outside single tone");
	a_upd_pulse: assert property (io_update_o |=> !io_update_o)
		else $error("internal update longer than one cycle");
	a_shadow_hold: assert property ($changed({opmode_o, amplitude_keying_en_o, three_wire_o,
		lsb_first_o}) |-> $past(io_update_o) || $past(io_update_i, 3))
		else $error("active setting changed without update");
endmodule

bind ucc_ctl ucc_ctl_chk #(.FLUSH_CYCLES(FLUSH_CYCLES)) ucc_ctl_chk_i (.*);

// ---- dv/ucc_host_model.sv ----
// Host model shifting frames over the serial programming port
`timescale 1ns/10ps
module ucc_host_model (
	input wire logic ref_clk_i,
	input wire logic lsb_i,
	input wire logic rd_bit_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic sdio_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdio_o = 1'b0;
	end
	// Four cycles per half keeps above the synchroniser minimum
	task automatic half();
		repeat (4) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic frame(input logic rd, input logic [4:0] ad, input logic [31:0] wd,
		output logic [31:0] rd_q);
		logic [39:0] w;
		int k;
		w = {rd, 2'b00, ad, wd};
		rd_q = '0;
		cs_n_o = 1'b0;
		for (int i = 0; i < 40; i++) begin
			k = lsb_i ? (i < 8 ? 32 + i : i - 8) : 39 - i;
			// Released line toggles so a stale level is never read back
			sdio_o = (rd && i > 7) ? ~sdio_o : w[k];
			half();
			if (rd && i > 7) rd_q[k] = rd_bit_i;
			sclk_o = 1'b1;
			half();
			sclk_o = 1'b0;
		end
		half();
		cs_n_o = 1'b1;
		sdio_o = ~sdio_o;
		half();
	endtask
endmodule

// ---- dv/testbench.sv ----
// Self-checking testbench for the control register block
`timescale 1ns/10ps
`include "ucc_regs.svh"
module testbench;
	localparam int FL = 3;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic io_upd = 1'b0;
	logic txen = 1'b1;
	logic ext = 1'b0;
	logic sclk, cs_n, hsdio, sdio_o, sdio_oe, sdo_o, sdo_oe, upd_o;
	wire [18:0] got;
	logic [31:0] s1 = '0, s2 = '0, a1 = '0, a2 = '0, r;
	int seed = 32'h5543;
	int n_mismatch = 0;
	int num_checks = 0;
	int k;
	int n_upd = 0;

	initial begin
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	ucc_ctl #(.FLUSH_CYCLES(FL)) ucc_ctl_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(sdio_oe ? sdio_o : hsdio), .sdio_o(sdio_o),
		.sdio_oe_o(sdio_oe), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe), .io_update_i(io_upd),
		.io_update_o(upd_o), .io_update_oe_o(got[0]), .transmit_enable_pin_i(txen),
		.external_powerdown_pin_i(ext), .opmode_o(got[18:17]), .amplitude_keying_en_o(got[16]),
		.amplitude_keying_auto_o(got[15]), .core_clk_en_o(got[14]), .bb_flush_o(got[13]),
		.dac_pd_o(got[12]), .reference_clock_input_pd_o(got[11]), .aux_dac_pd_o(got[10]), .full_pd_o(got[9]),
		.fast_pd_o(got[8]), .three_wire_o(got[7]), .lsb_first_o(got[6]),
		.dual_serial_host_port_en_o(got[5]), .dual_serial_lsb_first_o(got[4]),
		.dual_serial_early_fsync_o(got[3]), .amplitude_scale_factor_profile_o(got[2]),
		.amplitude_scale_factor_bypass_o(got[1]));

	// Undriven pin reads back inverted, so a missing enable shows up
	ucc_host_model ucc_host_model_i (.ref_clk_i(ref_clk_i), .lsb_i(a1[0]),
		.rd_bit_i(a1[1] ? (sdo_oe ? sdo_o : ~sdo_o) : (sdio_oe ? sdio_o : ~sdio_o)),
		.sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(hsdio));

	// Counted away from the launching edge
	always @(negedge ref_clk_i) begin
		if (upd_o === 1'b1) begin
			n_upd++;
		end
	end

	function automatic logic [18:0] exp_out(logic [31:0] a, logic [31:0] b, logic p);
		logic t;
		logic d;
		t = a[25:24] == 2'h1 && !a[9];
		d = b[31] && a[25:24] == 2'h0;
		return {a[25:24], a[9], a[9] & a[8], !a[7], 1'b0, a[6:4], p & !a[3], p & a[3], a[1:0],
			d, d & b[30], d & b[29], t & b[24], t & !b[24], b[23]};
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic wr(input logic [4:0] ad, input logic [31:0] d);
		logic iu;
		ucc_host_model_i.frame(1'b0, ad, d, r);
		cyc(12);
		s1 = (ad == `UCC_ADDR_CFG1) ? d & `UCC_C1_MASK : s1;
		s2 = (ad == `UCC_ADDR_CFG2) ? d & `UCC_C2_MASK : s2;
		a1[7] = s1[7];
		a1[5] = s1[5];
		a2[23] = s2[23];
		// Mode bit lands first, so the write that sets it also updates
		iu = s2[23];
		a1 = iu ? s1 : a1;
		a2 = iu ? s2 : a2;
	endtask
	task automatic rd(input logic [4:0] ad, input logic [31:0] e);
		ucc_host_model_i.frame(1'b1, ad, $random(seed), r);
		cyc(4);
		chk(r, e);
	endtask
	task automatic upd();
		io_upd = 1'b1;
		cyc(8);
		io_upd = 1'b0;
		cyc(8);
		a1 = s1;
		a2 = s2;
	endtask
	task automatic outs();
		chk(32'(got), 32'(exp_out(a1, a2, ext)));
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		#500000;
		n_mismatch++;
		print_verdict();
	end

	initial begin
		cyc(2);
		rstn_i = 1'b1;
		cyc(2);
		outs();
		rd(`UCC_ADDR_CFG1, 32'h0);
		rd(`UCC_ADDR_CFG2, 32'h0);
		$display("test reset done");
		// First two passes are fixed corners, the rest random
		for (int i = 0; i < 14; i++) begin
			ext = 1'($random(seed));
			wr(`UCC_ADDR_CFG1, i == 0 ? 32'h01000000 : i == 1 ? 32'h0 : $random(seed));
			wr(`UCC_ADDR_CFG2, (i < 2 ? 32'he1000000 : $random(seed)) & 32'hff7fffff);
			rd(`UCC_ADDR_CFG1, s1);
			rd(`UCC_ADDR_CFG2, s2);
			outs();
			upd();
			outs();
		end
		wr(5'h02, 32'hffffffff);
		rd(5'h02, 32'h0);
		rd(`UCC_ADDR_CFG1, s1);
		$display("test random done");
		k = n_upd;
		wr(`UCC_ADDR_CFG2, 32'h00800000);
		chk(n_upd - k, 1);
		k = n_upd;
		wr(`UCC_ADDR_CFG1, 32'h00000300);
		chk(n_upd - k, 1);
		outs();
		k = n_upd;
		wr(`UCC_ADDR_CFG2, 32'h0);
		chk(n_upd - k, 0);
		outs();
		$display("test internal update done");
		wr(`UCC_ADDR_CFG1, 32'h00000004);
		upd();
		txen = 1'b0;
		k = 0;
		while (got[13] !== 1'b1 && k < 20) begin
			cyc(1);
			k++;
		end
		k = 0;
		while (got[13] === 1'b1 && k < 20) begin
			cyc(1);
			k++;
		end
		chk(k, FL);
		chk(got[14], 1'b0);
		txen = 1'b1;
		cyc(8);
		chk(got[14], 1'b1);
		wr(`UCC_ADDR_CFG1, 32'h01000004);
		upd();
		txen = 1'b0;
		cyc(20);
		outs();
		txen = 1'b1;
		$display("test auto power-down done");
		print_verdict();
	end
endmodule
